// ==== logic/wssu_defs.svh ====
// Constants for the word shift/subtract execution slice.
// Assumes the standard 32-bit instruction layout of the core.
`ifndef WSSU_DEFS_SVH
`define WSSU_DEFS_SVH
`define WSSU_OP_HI          31
`define WSSU_OP_LO          26
`define WSSU_FS_HI          25
`define WSSU_FS_LO          21
`define WSSU_SS_HI          20
`define WSSU_SS_LO          16
`define WSSU_DST_HI         15
`define WSSU_DST_LO         11
`define WSSU_AMT_HI         10
`define WSSU_AMT_LO         6
`define WSSU_FN_HI          5
`define WSSU_FN_LO          0
`define WSSU_OP_ZERO        6'h00
`define WSSU_FN_SLF         6'h00
`define WSSU_FN_SRLF        6'h02
`define WSSU_FN_SRAF        6'h03
`define WSSU_FN_SRLR        6'h06
`define WSSU_FN_SRAR        6'h07
`define WSSU_FN_SUBT        6'h22
`define WSSU_SSNOP_AMT      5'h01
`define WSSU_ZERO5          5'h00
`endif

// ==== logic/wssu_pkg.sv ====
// Types for the word shift/subtract execution slice.
// Assumes wssu_defs.svh is available on the include path.
package wssu_pkg;
    typedef enum logic [2:0]
    {
        WSSU_OP_NONE  = 3'h0,
        WSSU_OP_SRLF  = 3'h1,
        WSSU_OP_SRAF  = 3'h3,
        WSSU_OP_SRLR  = 3'h2,
        WSSU_OP_SRAR  = 3'h6,
        WSSU_OP_SUBT  = 3'h7,
        WSSU_OP_SSNOP = 3'h5
    } wssu_op_t;
endpackage : wssu_pkg

// ==== logic/wssu_dec_if.sv ====
// Decoded-operation bundle between decoder and datapath.
// Assumes one clock; all signals are combinational from the decoder.
`timescale 1ns/1ns
interface wssu_dec_if;
    import wssu_pkg::*;
    wssu_op_t    op;
    logic [4:0]  amount;
    logic [4:0]  dest;
    logic        arith;
    modport dec (output op, output amount, output dest, output arith);
    modport dp  (input op, input amount, input dest, input arith);
endinterface : wssu_dec_if

// ==== logic/wssu_decode.sv ====
// Instruction decoder for the shift/subtract slice.
// Assumes the instruction word and first source value are same-clock signals.
`timescale 1ns/1ns
`include "wssu_defs.svh"
module wssu_decode
    import wssu_pkg::*;
(
    // Instruction and first source value
    input  wire logic [31:0] instr,
    input  wire logic [31:0] first_source_val,
    // Decoded bundle
    wssu_dec_if.dec          dec
);
    // ==========================================================
    // Field extraction
    wire logic [5:0] opc     = instr[`WSSU_OP_HI:`WSSU_OP_LO];
    wire logic [5:0] fn      = instr[`WSSU_FN_HI:`WSSU_FN_LO];
    wire logic [4:0] fs_fld  = instr[`WSSU_FS_HI:`WSSU_FS_LO];
    wire logic [4:0] ss_fld  = instr[`WSSU_SS_HI:`WSSU_SS_LO];
    wire logic [4:0] dst_fld = instr[`WSSU_DST_HI:`WSSU_DST_LO];
    wire logic [4:0] amt_fld = instr[`WSSU_AMT_HI:`WSSU_AMT_LO];
    wire logic       zop     = (opc == `WSSU_OP_ZERO);
    wire logic       fs_z    = (fs_fld == `WSSU_ZERO5);
    wire logic       amt_z   = (amt_fld == `WSSU_ZERO5);
    // Encoding matches; reserved fields must be zero
    wire logic is_sraf  = zop && fn == `WSSU_FN_SRAF && fs_z;
    wire logic is_srar  = zop && fn == `WSSU_FN_SRAR && amt_z;
    wire logic is_srlf  = zop && fn == `WSSU_FN_SRLF && fs_z;
    wire logic is_srlr  = zop && fn == `WSSU_FN_SRLR && amt_z;
    wire logic is_subt  = zop && fn == `WSSU_FN_SUBT && amt_z;
    wire logic is_ssnop = zop && fn == `WSSU_FN_SLF && fs_z && ss_fld == `WSSU_ZERO5
                          && dst_fld == `WSSU_ZERO5 && amt_fld == `WSSU_SSNOP_AMT;
    wire logic is_var   = is_srar || is_srlr;
    // Operation select, priority order is moot since encodings are disjoint
    assign dec.op = is_ssnop ? WSSU_OP_SSNOP :
                    is_sraf  ? WSSU_OP_SRAF  :
                    is_srar  ? WSSU_OP_SRAR  :
                    is_srlf  ? WSSU_OP_SRLF  :
                    is_srlr  ? WSSU_OP_SRLR  :
                    is_subt  ? WSSU_OP_SUBT  : WSSU_OP_NONE;
    // Only bits 4..0 of the count register matter
    assign dec.amount = is_var ? first_source_val[4:0] : amt_fld;
    assign dec.dest   = dst_fld;
    assign dec.arith  = is_sraf || is_srar;
endmodule : wssu_decode

// ==== logic/wssu_shifter.sv ====
// Barrel right shifter, arithmetic or logical.
// Assumes a purely combinational use; no state.
`timescale 1ns/1ns
module wssu_shifter
(
    // Operand and control
    input  wire logic [31:0] src,
    input  wire logic [4:0]  amount,
    input  wire logic        arith,
    // Result
    output logic      [31:0] result
);
    // ==========================================================
    // Five log stages; fill bit is sign or zero
    wire logic fill = arith & src[31];
    logic [31:0] stage [0:5];
    assign stage[0] = src;
    genvar g;
    generate
        for (g = 0; g < 5; g++)
        begin : g_stage
            assign stage[g+1] = amount[g] ?
                {{(1 << g){fill}}, stage[g][31:(1 << g)]} : stage[g];
        end
    endgenerate
    // Zero count passes the word through
    assign result = stage[5];
endmodule : wssu_shifter

// ==== logic/wssu_top.sv ====
// Word shift/subtract execution slice: right shifts, trapping subtract,
// superscalar no-op issue break.
// Assumes decode/issue and the register file run on clk_sys and present
// instr_valid with operands already read; write port and exception outputs are registered one stage, issue controls are combinational.
`timescale 1ns/1ns
`include "wssu_defs.svh"
module wssu_top
    import wssu_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    // Issue slot from decode/issue
    input  wire logic        instr_valid,
    input  wire logic [31:0] instr,
    input  wire logic [31:0] first_source_val,
    input  wire logic [31:0] second_source_val,
    // Issue control back to issue logic
    output logic             issue_solo,
    output logic             issue_hold_next,
    // Register write port
    output logic             wr_en_q,
    output logic [4:0]       wr_addr_q,
    output logic [31:0]      wr_data_q,
    // Exception
    output logic             ovf_exc_q
);
    // ==========================================================
    // Decode
    wssu_dec_if dec_bus ();
    wssu_decode u_decode
    (
        .instr            (instr),
        .first_source_val (first_source_val),
        .dec              (dec_bus.dec)
    );
    // ==========================================================
    // Shift datapath, operand is the second source register
    logic [31:0] shift_res;
    wssu_shifter u_shift
    (
        .src    (second_source_val),
        .amount (dec_bus.amount),
        .arith  (dec_bus.arith),
        .result (shift_res)
    );
    // ==========================================================
    // Subtract with 33-bit sign-extended operands
    wire logic [32:0] diff   = {first_source_val[31], first_source_val}
                             - {second_source_val[31], second_source_val};
    wire logic        ovf    = diff[32] ^ diff[31];
    wire logic        take   = instr_valid && clk_en;
    wire logic        is_sub = dec_bus.op == WSSU_OP_SUBT;
    wire logic        is_nop = dec_bus.op == WSSU_OP_SSNOP;
    wire logic        is_shf = dec_bus.op inside {WSSU_OP_SRAF, WSSU_OP_SRAR,
                                                  WSSU_OP_SRLF, WSSU_OP_SRLR};
    // Write only for shifts or non-overflowing subtract; the no-op writes nothing
    wire logic        wr_d   = take && (is_shf || (is_sub && !ovf));
    wire logic        exc_d  = take && is_sub && ovf;
    wire logic [31:0] data_d = is_sub ? diff[31:0] : shift_res;
    // ==========================================================
    // Issue-break signalling: combinational so no stall is added
    assign issue_solo      = instr_valid && is_nop;
    assign issue_hold_next = instr_valid && is_nop;
    // ==========================================================
    // Result stage; data held frozen while clock enable is low
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_en_q   <= 1'b0;
            wr_addr_q <= 5'h00;
            wr_data_q <= 32'h0000_0000;
            ovf_exc_q <= 1'b0;
        end
        else if (clk_en)
        begin
            wr_en_q   <= wr_d;
            wr_addr_q <= dec_bus.dest;
            wr_data_q <= data_d;
            ovf_exc_q <= exc_d;
        end
    end
    // ==========================================================
    // Checks
    sub_ovf_nowrite_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && instr_valid && is_sub && ovf |=> ovf_exc_q && !wr_en_q)
        else $error("overflow subtract wrote or missed exception");
    sub_result_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && instr_valid && is_sub && !ovf |=>
            wr_en_q && wr_data_q == $past(first_source_val) - $past(second_source_val))
        else $error("subtract result wrong");
    sub_ovf_detect_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && instr_valid && is_sub |=> ovf_exc_q ==
            (($past(first_source_val[31]) != $past(second_source_val[31])) &&
             ($past(first_source_val[31]) != $past(data_d[31]))))
        else $error("overflow detection wrong");

    // Shift results against a plain reference shift
    arith_fixed_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && instr_valid && dec_bus.op == WSSU_OP_SRAF |=>
            wr_data_q == 32'($signed($past(second_source_val)) >>> $past(instr[10:6])))
        else $error("fixed arithmetic shift wrong");

    arith_var_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && instr_valid && dec_bus.op == WSSU_OP_SRAR |=>
            wr_data_q == 32'($signed($past(second_source_val)) >>> $past(first_source_val[4:0])))
        else $error("variable arithmetic shift wrong");

    logic_fixed_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && instr_valid && dec_bus.op == WSSU_OP_SRLF |=>
            wr_data_q == ($past(second_source_val) >> $past(instr[10:6])))
        else $error("fixed logical shift wrong");

    logic_var_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && instr_valid && dec_bus.op == WSSU_OP_SRLR |=>
            wr_data_q == ($past(second_source_val) >> $past(first_source_val[4:0])))
        else $error("variable logical shift wrong");

    // Shift write port and the issue-break no-op
    shift_dest_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && instr_valid && is_shf |=> wr_en_q && !ovf_exc_q && wr_addr_q == $past(instr[15:11]))
        else $error("shift destination or exception wrong");

    ssnop_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && instr_valid && instr == 32'h0000_0040 |-> issue_solo ##1 !wr_en_q && !ovf_exc_q)
        else $error("issue-break no-op not recognised or changed state");

    // ==========================================================
    // Reference decode for the checks, taken straight from the word
    // so that a slip in the decoder cannot hide behind itself
    wire logic [5:0] chk_fn    = instr[`WSSU_FN_HI:`WSSU_FN_LO];
    wire logic       chk_zop   = instr[`WSSU_OP_HI:`WSSU_OP_LO] == `WSSU_OP_ZERO;
    wire logic       chk_hi0   = instr[`WSSU_FS_HI:`WSSU_FS_LO] == `WSSU_ZERO5;
    wire logic       chk_mid0  = instr[`WSSU_AMT_HI:`WSSU_AMT_LO] == `WSSU_ZERO5;
    wire logic       chk_fixed = chk_zop && chk_hi0 &&
                                 (chk_fn == `WSSU_FN_SRAF || chk_fn == `WSSU_FN_SRLF);
    wire logic       chk_var   = chk_zop && chk_mid0 &&
                                 (chk_fn == `WSSU_FN_SRAR || chk_fn == `WSSU_FN_SRLR);
    wire logic       chk_sub   = chk_zop && chk_mid0 && chk_fn == `WSSU_FN_SUBT;
    wire logic       chk_brk   = instr == {21'h0, `WSSU_SSNOP_AMT, `WSSU_FN_SLF};
    wire logic       chk_known = chk_fixed || chk_var || chk_sub || chk_brk;
    wire logic [4:0] chk_fcnt  = instr[`WSSU_AMT_HI:`WSSU_AMT_LO];
    wire logic [4:0] chk_vcnt  = first_source_val[4:0];
    wire logic [4:0] chk_dst   = instr[`WSSU_DST_HI:`WSSU_DST_LO];

    // ==========================================================
    // Decoder against the reference, every cycle
    brk_decode_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        is_nop == chk_brk)
        else $error("issue-break no-op decode wrong");

    fixed_decode_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        chk_fixed == (dec_bus.op inside {WSSU_OP_SRAF, WSSU_OP_SRLF}))
        else $error("fixed shift decode wrong");

    var_decode_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        chk_var == (dec_bus.op inside {WSSU_OP_SRAR, WSSU_OP_SRLR}))
        else $error("variable shift decode wrong");

    sub_decode_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        is_sub == chk_sub)
        else $error("trapping subtract decode wrong");

    // Shift count source; upper count-register bits must not leak in
    fixed_count_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        chk_fixed |-> dec_bus.amount == chk_fcnt)
        else $error("fixed shift count not from the amount field");

    var_count_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        chk_var |-> dec_bus.amount == chk_vcnt)
        else $error("variable shift count not from the low five bits");

    // ==========================================================
    // Result stage behaviour per kind of slot
    shift_noexc_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && instr_valid && (chk_fixed || chk_var) |=> wr_en_q && !ovf_exc_q)
        else $error("shift raised an exception or did not write");

    zero_pass_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && instr_valid && (chk_fixed || chk_var) && dec_bus.amount == 5'h00 |=>
            wr_data_q == $past(second_source_val))
        else $error("zero-count shift altered the word");

    sub_dest_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && instr_valid && chk_sub && !ovf |=>
            wr_en_q && wr_addr_q == $past(chk_dst))
        else $error("subtract destination wrong");

    // Equal signs can never overflow a subtract
    sub_nowrap_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && instr_valid && chk_sub &&
            first_source_val[31] == second_source_val[31] |=> wr_en_q && !ovf_exc_q)
        else $error("subtract flagged overflow with equal signs");

    refused_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && instr_valid && !chk_known |=> !wr_en_q && !ovf_exc_q)
        else $error("unrecognised encoding wrote or trapped");

    idle_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && !instr_valid |=> !wr_en_q && !ovf_exc_q)
        else $error("empty slot wrote or trapped");

    // ==========================================================
    // Issue-break signalling, same cycle, nothing else stalled
    brk_issue_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        instr_valid && chk_brk |-> issue_solo && issue_hold_next)
        else $error("issue break not signalled");

    brk_nostall_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(instr_valid && chk_brk) |-> !issue_solo && !issue_hold_next)
        else $error("issue break signalled without the no-op");

    // ==========================================================
    // Clock enable low freezes the result stage
    enable_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !clk_en |=> $stable(wr_en_q) && $stable(wr_addr_q) &&
            $stable(wr_data_q) && $stable(ovf_exc_q))
        else $error("result stage moved while clock enable low");

    // No disable here, since reset is what this one watches
    reset_clear_a: assert property (@(posedge clk_sys)
        !rst_b |-> !wr_en_q && !ovf_exc_q &&
            wr_addr_q == 5'h00 && wr_data_q == 32'h0000_0000)
        else $error("result stage not cleared in reset");
endmodule : wssu_top

// ==== sim/wssu_regfile_model.sv ====
// Register file model at the far side of the shift/subtract slice.
// Assumes reads by instruction field and one write port from the slice.
`timescale 1ns/1ns
module wssu_regfile_model
(
    // Clock
    input  wire logic        clk_sys,
    // Operand reads
    input  wire logic [31:0] instr,
    output logic      [31:0] first_source_val,
    output logic      [31:0] second_source_val,
    // Write port from the slice
    input  wire logic        wr_en_q,
    input  wire logic [4:0]  wr_addr_q,
    input  wire logic [31:0] wr_data_q
);
    // ==========================================================
    // Storage
    logic [31:0] regs [32];
    // Reads are combinational, as from an operand latch
    assign first_source_val  = regs[instr[25:21]];
    assign second_source_val = regs[instr[20:16]];
    // A write lands on the edge after the slice reports it
    always @(posedge clk_sys)
        if (wr_en_q)
            regs[wr_addr_q] <= wr_data_q;
    // Preload from the bench, off the clock edge
    task load(input logic [4:0] idx, input logic [31:0] val);
        regs[idx] = val;
    endtask : load
endmodule : wssu_regfile_model

// ==== sim/wssu_top_tb.sv ====
// Self-checking bench for the shift/subtract slice.
// Assumes operands come from the register file model.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module wssu_top_tb;
    import wssu_pkg::*;
    // ==========================================================
    // Signals
    logic        clk_sys = 1'b0;
    logic        rst_b;
    logic        clk_en = 1'b1;
    logic        instr_valid = 1'b0;
    logic [31:0] instr = 32'h0;
    logic [31:0] fsv, ssv, wr_data_q, p_d;
    logic        issue_solo, issue_hold_next, wr_en_q, ovf_exc_q;
    logic [4:0]  wr_addr_q, p_a;
    logic        p_wr = 1'b0;
    logic        p_ov = 1'b0;
    int          fails = 0;
    int          compares = 0;
    always #50 clk_sys = ~clk_sys;
    wssu_top wssu_top_inst (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
        .instr_valid(instr_valid), .instr(instr), .first_source_val(fsv),
        .second_source_val(ssv), .issue_solo(issue_solo),
        .issue_hold_next(issue_hold_next), .wr_en_q(wr_en_q),
        .wr_addr_q(wr_addr_q), .wr_data_q(wr_data_q), .ovf_exc_q(ovf_exc_q));
    wssu_regfile_model wssu_regfile_model_inst (.clk_sys(clk_sys), .instr(instr),
        .first_source_val(fsv), .second_source_val(ssv), .wr_en_q(wr_en_q),
        .wr_addr_q(wr_addr_q), .wr_data_q(wr_data_q));
    // ==========================================================
    // Drive one slot, check the previous one; back to back
    task automatic exec(input logic v, input logic [31:0] w);
        logic [32:0] d;
        logic [4:0]  n;
        logic        kf, kv, sh, sub;
        @(posedge clk_sys);
        instr_valid <= v;
        instr <= w;
        #1;
        `CHK("wr_en_q", p_wr, wr_en_q)
        `CHK("ovf_exc_q", p_ov, ovf_exc_q)
        if (p_wr)
        begin
            `CHK("wr_data_q", p_d, wr_data_q)
            `CHK("wr_addr_q", p_a, wr_addr_q)
        end
        `CHK("issue_solo", v && w == 32'h40, issue_solo)
        `CHK("issue_hold_next", v && w == 32'h40, issue_hold_next)
        d = {fsv[31], fsv} - {ssv[31], ssv};
        kf = v && w[31:26] == 6'h00 && w[25:21] == 5'h00;
        kv = v && w[31:26] == 6'h00 && w[10:6] == 5'h00;
        sh = w[5:3] == 3'h0 && w[1];
        sub = w[5:0] == 6'h22;
        n = w[2] ? fsv[4:0] : w[10:6];
        p_d = w[0] ? 32'($signed(ssv) >>> n) : ssv >> n;
        if (sub)
            p_d = d[31:0];
        p_ov = sub && kv && d[32] != d[31];
        p_wr = sh ? (w[2] ? kv : kf) : sub && kv && !p_ov;
        p_a = w[15:11];
    endtask : exec
    task automatic t_shifts;
        logic [4:0] amts [4] = '{5'h00, 5'h01, 5'h1f, 5'h11};
        wssu_regfile_model_inst.load(5'h02, 32'h8765_4321);
        wssu_regfile_model_inst.load(5'h03, 32'h4765_4321);
        wssu_regfile_model_inst.load(5'h04, 32'hffff_ffe5);
        wssu_regfile_model_inst.load(5'h05, 32'h0000_0020);
        wssu_regfile_model_inst.load(5'h06, 32'h0000_001f);
        foreach (amts[i])
            for (int s = 2; s < 4; s++)
            begin
                exec(1'b1, {11'h0, 5'(s), 5'h09, amts[i], 6'h03});
                exec(1'b1, {11'h0, 5'(s), 5'h0a, amts[i], 6'h02});
            end
        for (int c = 4; c < 7; c++)
        begin
            exec(1'b1, {6'h0, 5'(c), 5'h02, 5'h0b, 5'h0, 6'h07});
            exec(1'b1, {6'h0, 5'(c), 5'h02, 5'h0c, 5'h0, 6'h06});
        end
        $display("shifts done");
    endtask : t_shifts
    task automatic t_subtract;
        logic [31:0] ops [8] = '{32'h7fff_ffff, 32'hffff_ffff, 32'h8000_0000,
            32'h0000_0001, 32'h0000_0005, 32'h0000_0007, 32'h8000_0000, 32'h8000_0000};
        for (int i = 0; i < 8; i++)
            wssu_regfile_model_inst.load(5'(16 + i), ops[i]);
        for (int i = 0; i < 4; i++)
            exec(1'b1, {6'h0, 5'(16 + 2 * i), 5'(17 + 2 * i), 5'h0d, 5'h0, 6'h22});
        $display("subtract done");
    endtask : t_subtract
    task automatic t_refused;
        exec(1'b1, {6'h0, 5'h02, 5'h02, 5'h0e, 5'h03, 6'h02});
        exec(1'b1, {6'h0, 5'h04, 5'h02, 5'h0e, 5'h01, 6'h06});
        exec(1'b1, {6'h0, 5'h10, 5'h11, 5'h0e, 5'h01, 6'h22});
        exec(1'b1, {6'h0, 5'h00, 5'h02, 5'h0e, 5'h02, 6'h00});
        exec(1'b0, {11'h0, 5'h02, 5'h0e, 5'h01, 6'h03});
        $display("refusals done");
    endtask : t_refused
    // Freeze with a new slot pending, then a reset in mid-run
    task automatic t_freeze;
        exec(1'b1, {11'h0, 5'h02, 5'h09, 5'h08, 6'h02});
        @(posedge clk_sys);
        clk_en <= 1'b0;
        instr <= {11'h0, 5'h03, 5'h0a, 5'h01, 6'h03};
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK("held wr_en_q", 1'b1, wr_en_q)
        `CHK("held wr_data_q", p_d, wr_data_q)
        `CHK("held wr_addr_q", 5'h09, wr_addr_q)
        @(posedge clk_sys);
        rst_b <= 1'b0;
        #1;
        `CHK("reset wr_en_q", 1'b0, wr_en_q)
        `CHK("reset wr_data_q", 32'h0, wr_data_q)
        @(posedge clk_sys);
        rst_b <= 1'b1;
        clk_en <= 1'b1;
        instr_valid <= 1'b0;
        p_wr = 1'b0;
        p_ov = 1'b0;
        $display("freeze and reset done");
    endtask : t_freeze
    task automatic t_ssnop;
        wssu_regfile_model_inst.load(5'h00, 32'h5a5a_5a5a);
        exec(1'b1, {11'h0, 5'h02, 5'h0f, 5'h04, 6'h03});
        exec(1'b1, 32'h0000_0040);
        exec(1'b1, 32'h0000_0040);
        exec(1'b1, {11'h0, 5'h03, 5'h0f, 5'h04, 6'h02});
        exec(1'b0, 32'h0);
        exec(1'b0, 32'h0);
        `CHK("reg0", 32'h5a5a_5a5a, wssu_regfile_model_inst.regs[0])
        $display("issue break done");
    endtask : t_ssnop
    task stop_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    // Watchdog; the run itself is a fixed number of slots
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        stop_test();
    end
    initial
    begin
        rst_b <= 1'b0;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_shifts();
        t_subtract();
        t_refused();
        t_freeze();
        t_ssnop();
        stop_test();
    end
endmodule : wssu_top_tb
